// ---- design/timer8_ctc_waveform.sv ----
// 8-bit timer/counter with clear-on-match mode, waveform output and overflow flag
// Functional notes
// - A compare value written below the current count is missed until the counter wraps through 0xFF to 0x00.
// - With the compare output mode field at toggle, the waveform output inverts on every compare match.
// - The waveform reaches the pin only while the pin direction is output.
// - In clear-on-match mode, toggle frequency is the clock over two times prescale times one plus the compare value.
// - The prescaler divides by 1, 8, 64, 256 or 1024.
// - The overflow flag sets in the timer cycle where the count increments from 0xFF to 0x00; a clear-on-match at 0xFF does not set it.
`timescale 1ns/1ps
module timer8_ctc_waveform #(
  parameter int COUNT_W    = timer8_pkg::COUNT_W,
  parameter int PRESCALE_W = timer8_pkg::PRESCALE_W
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire logic [timer8_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [timer8_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                         reg_wr,
  input  wire logic                         reg_rd,
  output logic      [timer8_pkg::DATA_W-1:0] reg_rdata,
  output logic                              irq,
  output logic                              waveform_pin_out,
  output logic                              waveform_pin_oe
);
  import timer8_pkg::*;

  reg_req_t           req;
  timer_ctrl_t        ctrl;
  logic [COUNT_W-1:0] compare_value;
  logic [COUNT_W-1:0] count_value;
  logic [1:0]         status;
  logic [1:0]         mask;
  logic               pin_dir_out;
  logic               waveform_output;
  logic               tick;
  logic               match;
  logic               wrap;
  logic               count_write;
  logic [1:0]         clear_bits;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  timer8_prescaler #(
    .PRESCALE_W (PRESCALE_W)
  ) u_prescaler (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_sel (ctrl.clk_sel),
    .tick    (tick)
  );

  // Compare is exact equality, so a value below the count is only hit after a wrap
  assign match       = tick && (count_value == compare_value);
  assign wrap        = tick && (count_value == COUNT_MAX) && !(ctrl.ctc && match);
  assign count_write = req.wr && (req.addr == ADDR_COUNT);
  assign clear_bits  = (req.wr && req.addr == ADDR_STATUS) ? req.wdata[1:0] : 2'b00;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl          <= timer_ctrl_t'(CONTROL_RESET);
      compare_value <= COMPARE_RESET;
      mask          <= '0;
      pin_dir_out   <= 1'b0;
    end else if (req.wr) begin
      unique case (req.addr)
        ADDR_CONTROL: ctrl          <= timer_ctrl_t'(req.wdata[$bits(timer_ctrl_t)-1:0]);
        ADDR_COMPARE: compare_value <= req.wdata;
        ADDR_MASK:    mask          <= req.wdata[1:0];
        ADDR_PINDIR:  pin_dir_out   <= req.wdata[0];
        default:      ;
      endcase
    end
  end

  // A software write to the count wins over the timer tick and blocks that tick's match
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_value <= COUNT_BOTTOM;
    end else if (count_write) begin
      count_value <= req.wdata;
    end else if (ctrl.ctc && match) begin
      count_value <= COUNT_BOTTOM;
    end else if (tick) begin
      count_value <= count_value + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      waveform_output <= 1'b0;
    end else if (match && !count_write) begin
      unique case (ctrl.com)
        COM_TOGGLE:     waveform_output <= ~waveform_output;
        COM_CLEAR:      waveform_output <= 1'b0;
        COM_SET:        waveform_output <= 1'b1;
        COM_DISCONNECT: waveform_output <= waveform_output;
      endcase
    end
  end

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status[STAT_OVF_BIT]   <= (wrap && !count_write) ||
                                (status[STAT_OVF_BIT] && !clear_bits[STAT_OVF_BIT]);
      status[STAT_MATCH_BIT] <= (match && !count_write) ||
                                (status[STAT_MATCH_BIT] && !clear_bits[STAT_MATCH_BIT]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_CONTROL: reg_rdata <= {2'b00, ctrl};
        ADDR_COMPARE: reg_rdata <= compare_value;
        ADDR_COUNT:   reg_rdata <= count_value;
        ADDR_STATUS:  reg_rdata <= {6'h00, status};
        ADDR_MASK:    reg_rdata <= {6'h00, mask};
        ADDR_PINDIR:  reg_rdata <= {7'h00, pin_dir_out};
        default:      reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  assign irq = |(status & mask);

  // Pin shows the waveform only when driven as output and the compare output is connected
  assign waveform_pin_oe  = pin_dir_out;
  assign waveform_pin_out = pin_dir_out && (ctrl.com != COM_DISCONNECT) && waveform_output;
endmodule

// ---- design/timer8_pkg.sv ----
// Shared constants and types for the 8-bit clear-on-match timer
package timer8_pkg;
  localparam int          COUNT_W      = 8;
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 8;
  localparam int          PRESCALE_W   = 10;
  localparam logic [7:0]  COUNT_MAX    = 8'hFF;
  localparam logic [7:0]  COUNT_BOTTOM = 8'h00;

  localparam logic [3:0]  ADDR_CONTROL = 4'h0;
  localparam logic [3:0]  ADDR_COMPARE = 4'h1;
  localparam logic [3:0]  ADDR_COUNT   = 4'h2;
  localparam logic [3:0]  ADDR_STATUS  = 4'h3;
  localparam logic [3:0]  ADDR_MASK    = 4'h4;
  localparam logic [3:0]  ADDR_PINDIR  = 4'h5;

  localparam int          CTRL_CLKSEL_LSB = 0;
  localparam int          CTRL_MODE_BIT   = 3;
  localparam int          CTRL_COM_LSB    = 4;
  localparam int          STAT_OVF_BIT    = 0;
  localparam int          STAT_MATCH_BIT  = 1;

  localparam logic [1:0]  COM_DISCONNECT = 2'h0;
  localparam logic [1:0]  COM_TOGGLE     = 2'h1;
  localparam logic [1:0]  COM_CLEAR      = 2'h2;
  localparam logic [1:0]  COM_SET        = 2'h3;

  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [7:0]  COMPARE_RESET = 8'h00;

  typedef enum logic [2:0] {
    CLK_STOP, CLK_DIV1, CLK_DIV8, CLK_DIV64, CLK_DIV256, CLK_DIV1024, CLK_RSVD6, CLK_RSVD7
  } clk_sel_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] com;
    logic       ctc;
    clk_sel_t   clk_sel;
  } timer_ctrl_t;
endpackage

// ---- design/timer8_prescaler.sv ----
// Free-running prescaler producing the timer clock enable tick
`timescale 1ns/1ps
module timer8_prescaler #(
  parameter int PRESCALE_W = 10
) (
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  input  timer8_pkg::clk_sel_t     clk_sel,
  output logic                     tick
);
  import timer8_pkg::*;

  logic [PRESCALE_W-1:0] div_count;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      div_count <= '0;
    end else begin
      div_count <= div_count + 1'b1;
    end
  end

  // Tick when the low bits of the divider wrap; stopped clock never ticks
  always_comb begin
    unique case (clk_sel)
      CLK_DIV1:    tick = 1'b1;
      CLK_DIV8:    tick = &div_count[2:0];
      CLK_DIV64:   tick = &div_count[5:0];
      CLK_DIV256:  tick = &div_count[7:0];
      CLK_DIV1024: tick = &div_count[9:0];
      default:     tick = 1'b0;
    endcase
  end
endmodule

// ---- verification/timer8_ctc_properties.sv ----
// Port-level checker for the clear-on-match timer
`timescale 1ns/1ps
module timer8_ctc_properties (
  input wire logic                         ref_clk,
  input wire logic                         rst_n,
  input wire logic [timer8_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer8_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [timer8_pkg::DATA_W-1:0] reg_rdata,
  input wire logic                         irq,
  input wire logic                         waveform_pin_out,
  input wire logic                         waveform_pin_oe
);
  import timer8_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  timer_ctrl_t ctl;
  logic [7:0]  cmp;
  logic [19:0] gap;
  logic        last;
  logic        armed;
  wire         seen = waveform_pin_out != last;
  wire  [10:0] n = ctl.clk_sel == CLK_DIV1 ? 11'h001 : ctl.clk_sel == CLK_DIV8 ? 11'h008 :
                   ctl.clk_sel == CLK_DIV64 ? 11'h040 : ctl.clk_sel == CLK_DIV256 ? 11'h100 :
                   ctl.clk_sel == CLK_DIV1024 ? 11'h400 : 11'h000;
  wire         cfg = ctl.ctc && ctl.com == COM_TOGGLE && waveform_pin_oe && n != 11'h000;
  wire  [19:0] per = n * (cmp + 20'h00001);
  always_ff @(posedge ref_clk) begin
    if (!rst_n) ctl <= '0;
    else if (reg_wr && reg_addr == ADDR_CONTROL) ctl <= timer_ctrl_t'(reg_wdata[5:0]);
    if (!rst_n) cmp <= 8'h00;
    else if (reg_wr && reg_addr == ADDR_COMPARE) cmp <= reg_wdata;
  end
  // Any write may shift the phase, so a period is only judged between two untouched toggles
  always_ff @(posedge ref_clk) begin
    last <= waveform_pin_out;
    gap <= (!rst_n || reg_wr || seen) ? 20'h00000 : gap + 20'h00001;
    armed <= (!rst_n || reg_wr) ? 1'b0 : (armed || seen);
  end
  pin_gate_a:
    assert property (!waveform_pin_oe |-> !waveform_pin_out) else $error("pin shows wave as input");
  dir_write_a:
    assert property (reg_wr && reg_addr == ADDR_PINDIR |=> waveform_pin_oe == $past(reg_wdata[0]))
      else $error("pin direction not taken");
  toggle_period_a:
    assert property (cfg && armed && seen |-> gap == per - 20'h00001) else $error("toggle period wrong");
  mode_gate_a:
    assert property ($changed(waveform_pin_out) && $stable(waveform_pin_oe) && !$past(reg_wr)
      |-> ctl.com != COM_DISCONNECT) else $error("pin moved with output mode off");
  irq_mask_a:
    assert property (reg_wr && reg_addr == ADDR_MASK && reg_wdata == 8'h00 |=> !irq) else $error("masked irq");
  rdata_idle_a:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data outside read slot");
  cover property (cfg && armed && seen);
  cover property ($rose(irq));
  cover property ($fell(waveform_pin_oe));
endmodule

bind timer8_ctc_waveform timer8_ctc_properties chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .irq, .waveform_pin_out, .waveform_pin_oe);

// ---- verification/timer8_ctc_waveform_tb.sv ----
// Self-checking bench for the clear-on-match timer
`timescale 1ns/1ps
module timer8_ctc_waveform_tb;
  import timer8_pkg::*;
  logic       ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, irq, pin, oe;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, got, c;
  logic [3:0] regs [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hF};
  int         bad_count = 0, checks_done = 0, cyc = 0, w;
  timer8_ctc_waveform dut (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .waveform_pin_out(pin), .waveform_pin_oe(oe));
  initial forever #2.5 ref_clk = ~ref_clk;
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      results();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    // Let the design's update from this edge settle before anyone samples it
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 got = reg_rdata;
  endtask
  task automatic chk(input logic [19:0] e, input logic [19:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask
  // Counts clocks until the pin leaves level p
  task automatic stepw(input logic p);
    w = 0;
    while (pin === p && w < 9000) begin
      @(posedge ref_clk);
      #1 w++;
    end
  endtask
  function automatic int per(int s, int v);
    return (s == 1 ? 1 : s == 2 ? 8 : s == 3 ? 64 : s == 4 ? 256 : 1024) * (v + 1);
  endfunction
  initial begin
    void'($urandom(32126));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(20'h00000, {12'h000, got});
    end
    chk(20'h00000, {18'h00000, oe, pin});
    wr(ADDR_PINDIR, 8'h01);
    for (int s = 1; s <= 5; s++) begin
      c = (s == 1) ? 8'h00 : 8'($urandom_range(s < 4 ? 20 : 2));
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_COMPARE, c);
      wr(ADDR_COUNT, 8'h00);
      wr(ADDR_CONTROL, {2'h0, COM_TOGGLE, 1'b1, 3'(s)});
      stepw(pin);
      stepw(pin);
      chk(20'(per(s, int'(c))), 20'(w));
    end
    wr(ADDR_PINDIR, 8'h00);
    chk(20'h00000, {18'h00000, oe, pin});
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_STATUS, 8'hFF);
    wr(ADDR_MASK, 8'h01);
    wr(ADDR_COMPARE, 8'h10);
    wr(ADDR_COUNT, 8'h20);
    wr(ADDR_CONTROL, 8'h19);
    repeat (150) @(posedge ref_clk);
    rd(ADDR_STATUS);
    chk(20'h00000, {12'h000, got});
    for (w = 0; irq !== 1'b1 && w < 150; w++) @(posedge ref_clk);
    rd(ADDR_STATUS);
    chk(20'h00001, {12'h000, got});
    wr(ADDR_MASK, 8'h00);
    chk(20'h00000, {19'h00000, irq});
    wr(ADDR_STATUS, 8'h03);
    wr(ADDR_MASK, 8'h01);
    repeat (600) @(posedge ref_clk);
    chk(20'h00000, {19'h00000, irq});
    results();
  end
endmodule
